//--- iwsh_dev_model.sv
`timescale 1ns/1ps
module iwsh_dev_model #(
    parameter [6:0] DEV_ADDR   = 7'h66,
    parameter       STRETCH_NS = 40
) (
    input  wire scl,
    input  wire sda,
    input  wire nackAll,
    input  wire stretch,
    output reg  sdaLow,
    output reg  sclLow
);
    reg [15:0] mem [0:63];
    reg [15:0] addr;
    reg [7:0]  shiftReg, hiByte, txByte, byteIdx;
    reg [3:0]  bitCnt;
    reg        active, rd;
    integer    i;
    // Word memory preloaded with a pattern so reads never return a blank
    initial
    begin
        for (i = 0; i < 64; i = i + 1)
            mem[i] = 16'hA500 + i[15:0];
        {addr, active, rd, sdaLow, sclLow, bitCnt, byteIdx} = 0;
    end
    // Start: data falls while clock is high
    always @(negedge sda)
    begin
        if (scl === 1'b1)
            {active, rd, bitCnt, byteIdx} = {2'b10, 4'h0, 8'h00};
    end
    // Stop: data rises while clock is high; nothing counts until the next start
    always @(posedge sda)
    begin
        if (scl === 1'b1)
            {active, sdaLow} = 2'b00;
    end
    // Bits sampled while clock is high; a refused read byte ends sending
    always @(posedge scl)
    begin
        if (active)
        begin
            if (bitCnt < 4'h8)
                shiftReg = {shiftReg[6:0], sda};
            else if (rd && byteIdx > 8'h01 && sda)
                active = 1'b0;
            bitCnt = bitCnt + 4'h1;
        end
    end
    // Data and acknowledge change only while clock is low
    always @(negedge scl)
    begin
        if (stretch)
        begin
            sclLow = 1'b1;
            sclLow <= #(STRETCH_NS) 1'b0;
        end
        if (active && bitCnt == 4'h8)
        begin
            sdaLow = 1'b0;
            if (!rd || byteIdx == 8'h00)
            begin
                sdaLow = 1'b1;
                case (byteIdx)
                    8'h00: if (shiftReg[7:1] == DEV_ADDR && !nackAll) rd = shiftReg[0];
                           else {active, sdaLow} = 2'b00;
                    8'h01: addr[15:8] = shiftReg;
                    8'h02: addr[7:0] = shiftReg;
                    default: if (byteIdx[0]) hiByte = shiftReg;
                             else {mem[addr[5:0]], addr} = {hiByte, shiftReg, addr + 16'h1};
                endcase
            end
            byteIdx = byteIdx + 8'h01;
        end
        else if (active && bitCnt == 4'h9)
        begin
            {bitCnt, sdaLow} = 5'h00;
            if (rd)
            begin
                txByte = byteIdx[0] ? mem[addr[5:0]][15:8] : mem[addr[5:0]][7:0];
                if (!byteIdx[0])
                    addr = addr + 16'h1;
                sdaLow = ~txByte[7];
            end
        end
        else if (active && rd && byteIdx > 8'h00)
            sdaLow = ~txByte[3'h7 - bitCnt[2:0]];
    end
endmodule // iwsh_dev_model

//--- iwsh_master.v
`timescale 1ns/1ps
// Functional notes
// - Start: data falls while clock high; host makes it to open a frame.
// - Stop: data rises while clock high; host makes it to close a frame.
// - Host sends the seven-bit device address right after start.
// - Direction bit after the address: high reads, low writes.
// - Frame carries a 16-bit base address and 16-bit data words.
// - Write: address upper, lower, then words upper byte first, then stop.
// - Option field: 01 ROM, 10 RAM, 11 both.
// - Host selects only the RAM target.
// - Read begins with an address-only write ended by stop.
// - Host acknowledges each received byte but the last to keep the device sending.
// - Host ends a read with not-acknowledge then stop; device releases data.
// - One bit per clock cycle; data stable and sampled while clock high.
`include "iwsh_regs.vh"

module iwsh_master #(
    parameter QUARTER = `IWSH_QUARTER
) (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire        cmdValid,
    input  wire        cmdRead,
    input  wire [15:0] cmdAddr,
    input  wire [7:0]  cmdWords,
    output wire        cmdReady,
    input  wire [15:0] wrData,
    output wire        wrTake,
    output reg  [15:0] rdData_reg,
    output reg         rdValid_reg,
    output reg         done_reg,
    output reg         ackError_reg,
    output wire        busy,
    input  wire        sclIn,
    output wire        sclOut,
    output reg         sclOen_n_reg,
    input  wire        sdaIn,
    output wire        sdaOut,
    output reg         sdaOen_n_reg
);
    localparam S_IDLE  = 5'h01;
    localparam S_START = 5'h02;
    localparam S_BYTE  = 5'h04;
    localparam S_STOP  = 5'h08;
    localparam S_GAP   = 5'h10;

    reg  [1:0]  rstSync_reg;
    reg  [1:0]  sclSync_reg;
    reg  [1:0]  sdaSync_reg;
    reg  [4:0]  state_reg;
    reg  [9:0]  qCnt_reg;
    reg  [1:0]  phase_reg;
    reg  [3:0]  bitCnt_reg;
    reg  [2:0]  kind_reg;
    reg  [7:0]  tx_reg;
    reg  [7:0]  rx_reg;
    reg         ackBit_reg;
    reg         readCmd_reg;
    reg         readPhase_reg;
    reg         readPend_reg;
    reg  [15:0] addr_reg;
    reg  [15:0] word_reg;
    reg  [7:0]  words_reg;
    reg         sclLow_next;
    reg         sdaLow_next;
    wire        rstN;
    wire        sclHigh;
    wire        sdaHigh;
    wire        stall;
    wire        tick;
    wire        rxMode;
    wire        nackNow;
    wire        byteEnd;
    wire        lastTick;

    // Reset release is synchronised so every flop past the synchroniser leaves reset on the same edge
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rstSync_reg <= 2'h0;
        else
            rstSync_reg <= {rstSync_reg[0], 1'h1};
    end
    assign rstN = rstSync_reg[1];

    // Bus pins come from outside; two flops before any use
    always @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
        end
        else
        begin
            sclSync_reg <= {sclSync_reg[0], sclIn};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
        end
    end
    assign sclHigh = sclSync_reg[1];
    assign sdaHigh = sdaSync_reg[1];

    // Open-drain lines only ever pull low; the pad resolves the level
    assign sclOut   = 1'h0;
    assign sdaOut   = 1'h0;
    assign cmdReady = (state_reg == S_IDLE);
    assign busy     = (state_reg != S_IDLE);

    // A released clock held low by the far end stretches the low phase
    assign stall    = sclOen_n_reg & ~sclHigh;
    assign tick     = (qCnt_reg == QUARTER - 1) & ~stall;
    assign lastTick = tick & (phase_reg == 2'h3);
    assign rxMode   = readPhase_reg & ((kind_reg == `IWSH_K_DHI) | (kind_reg == `IWSH_K_DLO));
    assign nackNow  = (kind_reg == `IWSH_K_DLO) & (words_reg == 8'h01);
    assign byteEnd  = (state_reg == S_BYTE) & lastTick & (bitCnt_reg == 4'h8);
    // Next word is fetched as the upper data byte of a write is loaded
    assign wrTake   = byteEnd & ~rxMode & ~ackBit_reg & ~readCmd_reg &
                      (((kind_reg == `IWSH_K_ALO) & (words_reg != 8'h00)) |
                       ((kind_reg == `IWSH_K_DLO) & (words_reg != 8'h01)));

    // Line drive per state and quarter phase; clock low in phases 0 and 1 of byte and stop states
    always @*
    begin
        sclLow_next = 1'h0;
        sdaLow_next = 1'h0;
        case (state_reg)
            S_IDLE:
                sdaLow_next = 1'h0;
            S_START:
                sdaLow_next = phase_reg[1];
            S_BYTE:
            begin
                sclLow_next = ~phase_reg[1];
                // Data holds through the quarter in which the clock falls, so it never moves on that edge
                if (phase_reg == 2'h0)
                    sdaLow_next = ~sdaOen_n_reg;
                else if (bitCnt_reg == 4'h8)
                    sdaLow_next = rxMode & ~nackNow;
                else
                    sdaLow_next = ~rxMode & ~tx_reg[7];
            end
            S_STOP:
            begin
                sclLow_next = ~phase_reg[1];
                // Hold first, so a falling clock never meets a falling data line as a false start
                sdaLow_next = (phase_reg == 2'h0) ? ~sdaOen_n_reg : (phase_reg != 2'h3);
            end
            S_GAP:
                sdaLow_next = 1'h0;
            default:
            begin
                sclLow_next = 1'h0;
                sdaLow_next = 1'h0;
            end
        endcase
    end

    // Sequencer: quarter timing, bit shifting and frame order
    always @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg     <= S_IDLE;
            qCnt_reg      <= 10'h000;
            phase_reg     <= 2'h0;
            bitCnt_reg    <= 4'h0;
            kind_reg      <= `IWSH_K_DEV;
            tx_reg        <= 8'hFF;
            rx_reg        <= 8'h00;
            ackBit_reg    <= 1'h0;
            readCmd_reg   <= 1'h0;
            readPhase_reg <= 1'h0;
            readPend_reg  <= 1'h0;
            addr_reg      <= 16'h0000;
            word_reg      <= 16'h0000;
            words_reg     <= 8'h00;
            rdData_reg    <= 16'h0000;
            rdValid_reg   <= 1'h0;
            done_reg      <= 1'h0;
            ackError_reg  <= 1'h0;
            sclOen_n_reg  <= 1'h1;
            sdaOen_n_reg  <= 1'h1;
        end
        else
        begin
            sclOen_n_reg <= ~sclLow_next;
            sdaOen_n_reg <= ~sdaLow_next;
            rdValid_reg  <= 1'h0;
            done_reg     <= 1'h0;
            if (state_reg != S_IDLE)
            begin
                if (tick)
                begin
                    qCnt_reg  <= 10'h000;
                    phase_reg <= phase_reg + 2'h1;
                end
                else if (!stall)
                    qCnt_reg <= qCnt_reg + 10'h001;
            end
            // Sample in the middle of the high clock phase
            if ((state_reg == S_BYTE) && tick && (phase_reg == 2'h2))
            begin
                if (bitCnt_reg == 4'h8)
                    ackBit_reg <= sdaHigh;
                else
                    rx_reg <= {rx_reg[6:0], sdaHigh};
            end
            if ((state_reg == S_BYTE) && lastTick && (bitCnt_reg != 4'h8))
            begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
                tx_reg     <= {tx_reg[6:0], 1'h1};
            end
            case (state_reg)
                S_IDLE:
                    if (cmdValid)
                    begin
                        state_reg     <= S_START;
                        qCnt_reg      <= 10'h000;
                        phase_reg     <= 2'h0;
                        readCmd_reg   <= cmdRead;
                        readPhase_reg <= 1'h0;
                        readPend_reg  <= 1'h0;
                        ackError_reg  <= 1'h0;
                        // Option field forced to RAM; ROM is too slow
                        addr_reg      <= {`IWSH_OPT_RAM, cmdAddr[`IWSH_OPT_LSB-1:0]};
                        words_reg     <= cmdWords;
                        kind_reg      <= `IWSH_K_DEV;
                        tx_reg        <= {`IWSH_DEV_ADDR, `IWSH_DIR_WRITE};
                    end
                S_START:
                    if (lastTick)
                    begin
                        state_reg  <= S_BYTE;
                        bitCnt_reg <= 4'h0;
                    end
                S_BYTE:
                    if (byteEnd)
                    begin
                        bitCnt_reg <= 4'h0;
                        if (!rxMode && ackBit_reg)
                        begin
                            // Missing acknowledge aborts the frame with a stop
                            ackError_reg <= 1'h1;
                            readPend_reg <= 1'h0;
                            state_reg    <= S_STOP;
                        end
                        else
                        begin
                            case (kind_reg)
                                `IWSH_K_DEV:
                                    if (readPhase_reg)
                                        kind_reg <= `IWSH_K_DHI;
                                    else
                                    begin
                                        kind_reg <= `IWSH_K_AHI;
                                        tx_reg   <= addr_reg[15:8];
                                    end
                                `IWSH_K_AHI:
                                begin
                                    kind_reg <= `IWSH_K_ALO;
                                    tx_reg   <= addr_reg[7:0];
                                end
                                `IWSH_K_ALO:
                                    if (readCmd_reg || (words_reg == 8'h00))
                                    begin
                                        state_reg    <= S_STOP;
                                        readPend_reg <= readCmd_reg & (words_reg != 8'h00);
                                    end
                                    else
                                    begin
                                        kind_reg <= `IWSH_K_DHI;
                                        tx_reg   <= wrData[15:8];
                                        word_reg <= wrData;
                                    end
                                `IWSH_K_DHI:
                                begin
                                    kind_reg <= `IWSH_K_DLO;
                                    if (rxMode)
                                        rdData_reg[15:8] <= rx_reg;
                                    else
                                        tx_reg <= word_reg[7:0];
                                end
                                default:
                                begin
                                    // Device steps its word address; host only counts
                                    words_reg <= words_reg - 8'h01;
                                    if (rxMode)
                                    begin
                                        rdData_reg[7:0] <= rx_reg;
                                        rdValid_reg     <= 1'h1;
                                    end
                                    if (words_reg == 8'h01)
                                        state_reg <= S_STOP;
                                    else
                                    begin
                                        kind_reg <= `IWSH_K_DHI;
                                        if (!rxMode)
                                        begin
                                            tx_reg   <= wrData[15:8];
                                            word_reg <= wrData;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                S_STOP:
                    if (lastTick)
                        state_reg <= S_GAP;
                S_GAP:
                    // Bus free time before any new start
                    if (lastTick)
                    begin
                        if (readPend_reg)
                        begin
                            readPend_reg  <= 1'h0;
                            readPhase_reg <= 1'h1;
                            state_reg     <= S_START;
                            kind_reg      <= `IWSH_K_DEV;
                            tx_reg        <= {`IWSH_DEV_ADDR, `IWSH_DIR_READ};
                        end
                        else
                        begin
                            state_reg <= S_IDLE;
                            done_reg  <= 1'h1;
                        end
                    end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

endmodule // iwsh_master

//--- iwsh_master_bench.sv
`timescale 1ns/1ps
module iwsh_master_bench;
    reg         clk_sys, arst_n, cmdValid, cmdRead, nackAll, stretch;
    reg  [15:0] cmdAddr, wrData;
    reg  [7:0]  cmdWords;
    wire [15:0] rdData_reg;
    wire        cmdReady, wrTake, rdValid_reg, done_reg, ackError_reg, busy;
    wire        sclOut, sclOen_n_reg, sdaOut, sdaOen_n_reg, sdaLow, sclLow;
    integer     mismatches, samples_checked, wi;
    reg  [15:0] wq [0:3];
    reg  [15:0] rq [$];
    // Pull-ups: a released line reads high unless someone pulls it
    wire sclWire = (sclOen_n_reg ? 1'b1 : sclOut) & ~sclLow;
    wire sdaWire = (sdaOen_n_reg ? 1'b1 : sdaOut) & ~sdaLow;
    iwsh_master #(.QUARTER(4)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .cmdValid(cmdValid), .cmdRead(cmdRead),
        .cmdAddr(cmdAddr), .cmdWords(cmdWords), .cmdReady(cmdReady), .wrData(wrData), .wrTake(wrTake),
        .rdData_reg(rdData_reg), .rdValid_reg(rdValid_reg), .done_reg(done_reg), .ackError_reg(ackError_reg),
        .busy(busy), .sclIn(sclWire), .sclOut(sclOut), .sclOen_n_reg(sclOen_n_reg), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOen_n_reg(sdaOen_n_reg));
    // Stretch outlasts the host's low phase so the stall path is really taken
    iwsh_dev_model #(.STRETCH_NS(80)) partner (.scl(sclWire), .sda(sdaWire), .nackAll(nackAll), .stretch(stretch),
        .sdaLow(sdaLow), .sclLow(sclLow));
    always #2.5 clk_sys = ~clk_sys;
    // Feed write words and gather read words
    always @(posedge clk_sys) if (wrTake === 1'b1) wi <= wi + 1;
    always @(negedge clk_sys) wrData <= wq[wi[1:0]];
    always @(posedge clk_sys) if (rdValid_reg === 1'b1) rq.push_back(rdData_reg);
    task check(input [15:0] got, input [15:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One command; with poke a read request stays up while busy and must be ignored
    task run_cmd(input rd, input [15:0] a, input [7:0] n, input poke);
        integer k;
    begin
        {wi, k} = 0;
        rq.delete();
        @(negedge clk_sys);
        {cmdValid, cmdRead, cmdAddr, cmdWords} = {1'b1, rd, a, n};
        @(negedge clk_sys);
        {cmdValid, cmdRead} = {poke, poke};
        while (done_reg !== 1'b1 && k < 20000)
        begin
            @(negedge clk_sys);
            k = k + 1;
        end
        cmdValid = 1'b0;
        check(16'(k < 20000), 16'h1);
    end
    endtask
    task test_write;
    begin
        {wq[0], wq[1], wq[2]} = {16'h1234, 16'hABCD, 16'h00FF};
        run_cmd(1'b0, 16'hC005, 8'h03, 1'b0);
        check(ackError_reg, 16'h0);
        check(partner.mem[5], 16'h1234);
        check(partner.mem[6], 16'hABCD);
        check(partner.mem[7], 16'h00FF);
        check(partner.addr, 16'h8008);
        $display("test_write end");
    end
    endtask
    task test_read;
    begin
        run_cmd(1'b1, 16'h0005, 8'h03, 1'b0);
        check(16'(rq.size()), 16'h3);
        check(rq[0], 16'h1234);
        check(rq[2], 16'h00FF);
        check(partner.active, 16'h0);
        $display("test_read end");
    end
    endtask
    task test_addr_only;
    begin
        run_cmd(1'b0, 16'h0006, 8'h00, 1'b1);
        check(partner.addr, 16'h8006);
        check(16'(rq.size() + wi), 16'h0);
        check(cmdReady, 16'h1);
        // A read of no words runs only the address frame
        run_cmd(1'b1, 16'h0009, 8'h00, 1'b0);
        check(partner.addr, 16'h8009);
        check(16'(rq.size()), 16'h0);
        $display("test_addr_only end");
    end
    endtask
    task test_nack;
    begin
        nackAll = 1'b1;
        wq[0] = 16'hDEAD;
        run_cmd(1'b0, 16'h0010, 8'h01, 1'b0);
        check(ackError_reg, 16'h1);
        check(partner.mem[16], 16'hA510);
        nackAll = 1'b0;
        $display("test_nack end");
    end
    endtask
    task test_stretch;
    begin
        stretch = 1'b1;
        wq[0] = 16'h5AA5;
        run_cmd(1'b0, 16'h003F, 8'h01, 1'b0);
        check(ackError_reg, 16'h0);
        run_cmd(1'b1, 16'h003F, 8'h01, 1'b0);
        check(rq[0], 16'h5AA5);
        stretch = 1'b0;
        $display("test_stretch end");
    end
    endtask
    task close_out;
    begin
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // Watchdog sized well above seven commands at the short quarter
    initial
    begin
        #(5 * 80000);
        mismatches = mismatches + 1;
        $display("[ERR] %0t watchdog expired", $time);
        close_out;
    end
    initial
    begin
        {clk_sys, arst_n, cmdValid, cmdRead, nackAll, stretch, cmdAddr, cmdWords} = 0;
        {mismatches, samples_checked, wi} = 0;
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        test_write;
        test_read;
        test_addr_only;
        test_nack;
        test_stretch;
        close_out;
    end
endmodule // iwsh_master_bench

//--- iwsh_master_properties.sv
`timescale 1ns/1ps
module iwsh_master_props #(
    parameter QUARTER = 4
) (
    input wire clk_sys,
    input wire arst_n,
    input wire cmdValid,
    input wire cmdReady,
    input wire wrTake,
    input wire done_reg,
    input wire ackError_reg,
    input wire busy,
    input wire sclOen_n_reg,
    input wire sdaOen_n_reg
);
    localparam int BIT = 4 * QUARTER;
    localparam int TAIL = 3 * BIT;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Judged on the host's own enables, so a stretching device cannot fake a bus edge
    property p_start; cmdValid && cmdReady |-> ##[1:BIT] (!sdaOen_n_reg && sclOen_n_reg); endproperty
    a_start: assert property (p_start) else $error("no start after accept");
    property p_clk_after_start; $fell(sdaOen_n_reg) && sclOen_n_reg && $past(sclOen_n_reg) |-> ##[1:BIT] !sclOen_n_reg; endproperty
    a_clk_after_start: assert property (p_clk_after_start) else $error("clock idle after start");
    property p_low_phase; $fell(sclOen_n_reg) |-> !sclOen_n_reg [*3]; endproperty
    a_low_phase: assert property (p_low_phase) else $error("clock low phase short");
    // A data rise under a high clock is a stop, so the bus must then stay free
    property p_stop_free; $rose(sdaOen_n_reg) && sclOen_n_reg && $past(sclOen_n_reg) |=> (sdaOen_n_reg && sclOen_n_reg) [*3]; endproperty
    a_stop_free: assert property (p_stop_free) else $error("bus not free after stop");
    property p_idle_free; cmdReady |-> sclOen_n_reg && sdaOen_n_reg; endproperty
    a_idle_free: assert property (p_idle_free) else $error("line held while idle");
    property p_done_idle; done_reg |-> cmdReady && !busy; endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while busy");
    property p_nack_end; $rose(ackError_reg) |-> ##[1:TAIL] done_reg; endproperty
    a_nack_end: assert property (p_nack_end) else $error("no end after refusal");
    property p_err_clear; cmdValid && cmdReady |=> !ackError_reg; endproperty
    a_err_clear: assert property (p_err_clear) else $error("error kept over accept");
    property p_take_busy; wrTake |-> busy && !cmdReady; endproperty
    a_take_busy: assert property (p_take_busy) else $error("word taken while idle");
endmodule // iwsh_master_props

bind iwsh_master iwsh_master_props #(.QUARTER(QUARTER)) u_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .wrTake(wrTake),
    .done_reg(done_reg), .ackError_reg(ackError_reg), .busy(busy), .sclOen_n_reg(sclOen_n_reg),
    .sdaOen_n_reg(sdaOen_n_reg));

//--- iwsh_regs.vh
`ifndef IWSH_REGS_VH
`define IWSH_REGS_VH
// System clock rate in kHz and bus clock rate in kHz
`define IWSH_CLK_KHZ    200000
`define IWSH_SCL_KHZ    100
// Quarter of a bus clock period in system cycles
`define IWSH_QUARTER    (`IWSH_CLK_KHZ / (`IWSH_SCL_KHZ * 4))
// Seven-bit device address, shared upper bits of the CC and CD bytes
`define IWSH_DEV_ADDR   7'h66
`define IWSH_DIR_WRITE  1'h0
`define IWSH_DIR_READ   1'h1
// Memory option field, carried in base address bits 15:14
`define IWSH_OPT_ROM    2'h1
`define IWSH_OPT_RAM    2'h2
`define IWSH_OPT_BOTH   2'h3
`define IWSH_OPT_MSB    15
`define IWSH_OPT_LSB    14
// Kind of the byte currently on the bus
`define IWSH_K_DEV      3'h0
`define IWSH_K_AHI      3'h1
`define IWSH_K_ALO      3'h2
`define IWSH_K_DHI      3'h3
`define IWSH_K_DLO      3'h4
`endif
